// ### pmw_device.sv
// Overview of operation
// - Deepest mode powers off all but wake pins.
// - Deepest mode left only by eight wake pins.
// - Five storage registers survive the deepest mode.
// - Lock bit refuses deepest mode entry.
// - Sleep stops core clock; enabled interrupt resumes.
// - Pin wake needs controller and start-zero enables.
// - Brownout wake needs three enables plus power.
// - Brownout reset in deep-sleep/power-down needs enable, power.
// - Software sets up watchdog and oscillator power.
// - Software sets up self-wake timer clock, enable.
// - Serial wake only as clocked slave.
// - Software switches touch clock, enables before sleep.
// - Wake pin acts only if enabled.
// - Start on free-running oscillator; switch after stable.
// - Chip reset merges pin, watchdog, power-on, brownout.
// - Reset restarts oscillator, inits flash, clears registers.
// - After reset fetching starts at address zero.
// - Three interrupt thresholds, four reset thresholds.
// - Brownout signal readable as status.
// - Selectable threshold forces full chip reset.
`timescale 1ns/1ps
`include "pmw_defines.svh"

module pmw_device (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Link to host
   pmw_if.device           lnk,
   // Wake and interrupt sources
   input  wire logic [7:0] pin_irq,
   input  wire logic [7:0] wake_pin_n,
   input  wire logic       wdt_irq,
   input  wire logic       wkt_irq,
   input  wire logic       serial_irq,
   input  wire logic       touch_irq,
   // Reset sources
   input  wire logic       rst_pin_n,
   input  wire logic       wdt_rst,
   input  wire logic       por,
   // Brownout comparators and oscillator status
   input  wire logic [3:0] supply_below,
   input  wire logic       lposc_stable,
   // Power controls
   output logic            logic_pwr_en,
   output logic            wake_pin_pwr_en,
   output logic            fro_en,
   output logic            fro_out_en,
   output logic [1:0]      flash_mode,
   output logic            flash_init,
   output logic            periph_rst,
   output logic            main_clk_sel
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   pmw_pkg::pmw_state_e state_reg, state_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic [31:0] gp_reg [`PMW_GP_REGS];
   logic [31:0] gp_next [`PMW_GP_REGS];
   logic [31:0] gp_rdata_reg, gp_rdata_next;
   logic        core_clk_reg, core_clk_next;
   logic        lpwr_reg, lpwr_next;
   logic        fro_reg, fro_next;
   logic        fro_out_reg, fro_out_next;
   logic [1:0]  flash_reg, flash_next;
   logic        rst_reg, rst_next;
   logic        fetch_reg, fetch_next;
   logic        clk_sel_reg, clk_sel_next;
   logic        bod_st_reg, bod_st_next;
   logic        bod_irq_reg, bod_irq_next;
   logic        ready_reg, ready_next;
   logic        refused_reg, refused_next;

   // ----------------------------------------------------------------------
   // Wake and reset qualification
   // ----------------------------------------------------------------------
   logic low_pwr;
   logic bod_int_lvl;
   logic bod_rst_hit;
   logic rst_src;
   logic any_irq;
   logic deep_wake;
   logic pin_wake;
   logic [4:0] misc_irq;

   always_comb begin
      low_pwr = (state_reg == pmw_pkg::PMW_ST_DSLEEP) ||
                (state_reg == pmw_pkg::PMW_ST_PDOWN);
      // Code 3 of the interrupt select is not a threshold and never fires.
      bod_int_lvl = (lnk.brownout_control_reg.int_sel != 2'h3) &&
         supply_below[lnk.brownout_control_reg.int_sel];
      bod_rst_hit = lnk.brownout_control_reg.rst_en &&
                    supply_below[lnk.brownout_control_reg.rst_sel] &&
                    (!low_pwr ||
                     lnk.sleep_power_config.bod_powered);
      rst_src = !rst_pin_n || wdt_rst || por || bod_rst_hit;
      misc_irq = {touch_irq, serial_irq, wkt_irq, wdt_irq, bod_irq_reg};
      any_irq = |(pin_irq & lnk.vectored_int_ctrl_pin_en) ||
                |(misc_irq & lnk.vectored_int_ctrl_misc_en);
      deep_wake = |(pin_irq & lnk.vectored_int_ctrl_pin_en &
                    lnk.start_enable_zero);
      deep_wake = deep_wake ||
                  (|(misc_irq & lnk.vectored_int_ctrl_misc_en & lnk.start_enable_one) &&
                   (!bod_irq_reg || lnk.brownout_control_reg.int_en) &&
                   (!bod_irq_reg ||
                    lnk.sleep_power_config.bod_powered));
      pin_wake = |(~wake_pin_n & lnk.wake_pin_enable_reg);
   end

   // ----------------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------------
   always_comb begin
      state_next   = state_reg;
      cnt_next     = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
      fetch_next   = 1'b0;
      refused_next = 1'b0;
      clk_sel_next = clk_sel_reg;
      unique case (state_reg)
         pmw_pkg::PMW_ST_RESET: begin
            if (!rst_src && cnt_reg == 4'h0) begin
               state_next = pmw_pkg::PMW_ST_RUN;
               fetch_next = 1'b1;
            end
         end
         pmw_pkg::PMW_ST_RUN: begin
            // Switching only on a stable oscillator avoids a runt clock.
            if (lnk.clk_sel_req == 1'b0 || ready_reg) begin
               clk_sel_next = lnk.clk_sel_req;
            end
            if (lnk.sleep_instr) begin
               unique case (lnk.mode_req)
                  pmw_pkg::PMW_MODE_SLEEP:
                     state_next = pmw_pkg::PMW_ST_SLEEP;
                  pmw_pkg::PMW_MODE_DSLEEP:
                     state_next = pmw_pkg::PMW_ST_DSLEEP;
                  pmw_pkg::PMW_MODE_PDOWN:
                     state_next = pmw_pkg::PMW_ST_PDOWN;
                  pmw_pkg::PMW_MODE_DPD: begin
                     if (lnk.dpd_lock) begin
                        refused_next = 1'b1;
                     end else begin
                        state_next = pmw_pkg::PMW_ST_DPD;
                     end
                  end
               endcase
            end
         end
         pmw_pkg::PMW_ST_SLEEP: begin
            if (any_irq) begin
               state_next = pmw_pkg::PMW_ST_RUN;
            end
         end
         pmw_pkg::PMW_ST_DSLEEP,
         pmw_pkg::PMW_ST_PDOWN: begin
            if (deep_wake) begin
               state_next = pmw_pkg::PMW_ST_RUN;
            end
         end
         pmw_pkg::PMW_ST_DPD: begin
            // Nothing else is powered, so only a wake pin can end it.
            if (pin_wake) begin
               state_next = pmw_pkg::PMW_ST_RESET;
               cnt_next   = 4'(`PMW_RST_HOLD_CYC);
            end
         end
         default: state_next = pmw_pkg::PMW_ST_RESET;
      endcase
      if (rst_src && state_reg != pmw_pkg::PMW_ST_DPD) begin
         state_next = pmw_pkg::PMW_ST_RESET;
         cnt_next   = 4'(`PMW_RST_HOLD_CYC);
         fetch_next = 1'b0;
      end
      if (state_next == pmw_pkg::PMW_ST_RESET) begin
         clk_sel_next = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Power and clock controls
   // ----------------------------------------------------------------------
   always_comb begin
      rst_next      = (state_next == pmw_pkg::PMW_ST_RESET);
      core_clk_next = (state_next == pmw_pkg::PMW_ST_RUN);
      lpwr_next     = (state_next != pmw_pkg::PMW_ST_DPD);
      fro_next      = (state_next != pmw_pkg::PMW_ST_PDOWN) &&
                      (state_next != pmw_pkg::PMW_ST_DPD);
      fro_out_next  = fro_next && (state_next != pmw_pkg::PMW_ST_DSLEEP);
      if (state_next == pmw_pkg::PMW_ST_DSLEEP) begin
         flash_next = 2'h1;
      end else if (state_next == pmw_pkg::PMW_ST_PDOWN ||
                   state_next == pmw_pkg::PMW_ST_DPD) begin
         flash_next = 2'h0;
      end else begin
         flash_next = 2'h2;
      end
      ready_next  = lposc_stable;
      bod_st_next = bod_int_lvl && lpwr_reg;
      bod_irq_next = bod_int_lvl && lpwr_reg &&
                     lnk.brownout_control_reg.int_en;
   end

   // ----------------------------------------------------------------------
   // Retained storage
   // ----------------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < `PMW_GP_REGS; i++) begin
         gp_next[i] = gp_reg[i];
         if (por) begin
            gp_next[i] = `PMW_GP_RST;
         end else if (lnk.gp_wr && state_reg == pmw_pkg::PMW_ST_RUN &&
                      lnk.gp_idx == 3'(i)) begin
            gp_next[i] = lnk.gp_wdata;
         end
      end
      gp_rdata_next = (lnk.gp_idx < 3'(`PMW_GP_REGS)) ?
                      gp_reg[lnk.gp_idx] : 32'h0000_0000;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg    <= pmw_pkg::PMW_ST_RESET;
         cnt_reg      <= 4'(`PMW_RST_HOLD_CYC);
         core_clk_reg <= 1'b0;
         lpwr_reg     <= 1'b1;
         fro_reg      <= 1'b1;
         fro_out_reg  <= 1'b1;
         flash_reg    <= 2'h2;
         rst_reg      <= 1'b1;
         fetch_reg    <= 1'b0;
         clk_sel_reg  <= 1'b0;
         bod_st_reg   <= 1'b0;
         bod_irq_reg  <= 1'b0;
         ready_reg    <= 1'b0;
         refused_reg  <= 1'b0;
         gp_rdata_reg <= `PMW_GP_RST;
         for (int i = 0; i < `PMW_GP_REGS; i++) begin
            gp_reg[i] <= `PMW_GP_RST;
         end
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         core_clk_reg <= core_clk_next;
         lpwr_reg     <= lpwr_next;
         fro_reg      <= fro_next;
         fro_out_reg  <= fro_out_next;
         flash_reg    <= flash_next;
         rst_reg      <= rst_next;
         fetch_reg    <= fetch_next;
         clk_sel_reg  <= clk_sel_next;
         bod_st_reg   <= bod_st_next;
         bod_irq_reg  <= bod_irq_next;
         ready_reg    <= ready_next;
         refused_reg  <= refused_next;
         gp_rdata_reg <= gp_rdata_next;
         for (int i = 0; i < `PMW_GP_REGS; i++) begin
            gp_reg[i] <= gp_next[i];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign lnk.pm_state    = state_reg;
   assign lnk.core_clk_en = core_clk_reg;
   assign lnk.chip_rst    = rst_reg;
   assign lnk.fetch_start = fetch_reg;
   assign lnk.fetch_addr  = `PMW_BOOT_ADDR;
   assign lnk.bod_irq     = bod_irq_reg;
   assign lnk.bod_status  = bod_st_reg;
   assign lnk.lposc_ready = ready_reg;
   assign lnk.dpd_refused = refused_reg;
   assign lnk.gp_rdata    = gp_rdata_reg;
   assign logic_pwr_en    = lpwr_reg;
   assign wake_pin_pwr_en = 1'b1;
   assign fro_en          = fro_reg;
   assign fro_out_en      = fro_out_reg;
   assign flash_mode      = flash_reg;
   assign flash_init      = rst_reg;
   assign periph_rst      = rst_reg;
   assign main_clk_sel    = clk_sel_reg;

endmodule

// ### pmw_defines.svh
`ifndef PMW_DEFINES_SVH
`define PMW_DEFINES_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define PMW_WAKE_PINS     8
`define PMW_GP_REGS       5
`define PMW_GP_IDX_W      3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PMW_CLK_NS        4
`define PMW_RST_PULSE_NS  50
`define PMW_RST_HOLD_CYC  ((`PMW_RST_PULSE_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)

// ----------------------------------------------------------------------
// Start-enable-one bit positions
// ----------------------------------------------------------------------
`define PMW_SE1_BOD       0
`define PMW_SE1_WDT       1
`define PMW_SE1_WKT       2
`define PMW_SE1_SER       3
`define PMW_SE1_TOUCH     4

// ----------------------------------------------------------------------
// Host command selectors
// ----------------------------------------------------------------------
`define PMW_SEL_MODE      4'h0
`define PMW_SEL_SE0       4'h1
`define PMW_SEL_SE1       4'h2
`define PMW_SEL_VECTORED_INT_CTRL      4'h3
`define PMW_SEL_BOD       4'h4
`define PMW_SEL_SPC       4'h5
`define PMW_SEL_WAKE      4'h6
`define PMW_SEL_CLK       4'h7
`define PMW_SEL_GP0       4'h8
`define PMW_SEL_GPRD      4'hd

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PMW_BOOT_ADDR     32'h0000_0000
`define PMW_GP_RST        32'h0000_0000

`endif

// ### pmw_pkg.sv
package pmw_pkg;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      PMW_MODE_SLEEP  = 2'h0,
      PMW_MODE_DSLEEP = 2'h1,
      PMW_MODE_PDOWN  = 2'h2,
      PMW_MODE_DPD    = 2'h3
   } pmw_mode_e;

   typedef enum logic [2:0] {
      PMW_ST_RESET  = 3'h0,
      PMW_ST_RUN    = 3'h1,
      PMW_ST_SLEEP  = 3'h3,
      PMW_ST_DSLEEP = 3'h2,
      PMW_ST_PDOWN  = 3'h6,
      PMW_ST_DPD    = 3'h7
   } pmw_state_e;

   typedef struct packed {
      logic       int_en;
      logic       rst_en;
      logic [1:0] int_sel;
      logic [1:0] rst_sel;
   } pmw_bod_ctrl_s;

   typedef struct packed {
      logic bod_powered;
      logic lposc_powered;
   } pmw_sleep_cfg_s;

endpackage

// ### pmw_if.sv
`timescale 1ns/1ps

interface pmw_if;
   // Host to device
   pmw_pkg::pmw_mode_e      mode_req;
   logic                    sleep_instr;
   logic                    dpd_lock;
   logic [7:0]              start_enable_zero;
   logic [4:0]              start_enable_one;
   logic [7:0]              vectored_int_ctrl_pin_en;
   logic [4:0]              vectored_int_ctrl_misc_en;
   pmw_pkg::pmw_bod_ctrl_s  brownout_control_reg;
   pmw_pkg::pmw_sleep_cfg_s sleep_power_config;
   logic [7:0]              wake_pin_enable_reg;
   logic                    clk_sel_req;
   logic                    gp_wr;
   logic [2:0]              gp_idx;
   logic [31:0]             gp_wdata;
   // Device to host
   pmw_pkg::pmw_state_e     pm_state;
   logic                    core_clk_en;
   logic                    chip_rst;
   logic                    fetch_start;
   logic [31:0]             fetch_addr;
   logic                    bod_irq;
   logic                    bod_status;
   logic                    lposc_ready;
   logic                    dpd_refused;
   logic [31:0]             gp_rdata;

   modport device (
      input  mode_req, sleep_instr, dpd_lock, start_enable_zero,
      input  start_enable_one, vectored_int_ctrl_pin_en, vectored_int_ctrl_misc_en,
      input  brownout_control_reg, sleep_power_config,
      input  wake_pin_enable_reg, clk_sel_req, gp_wr, gp_idx, gp_wdata,
      output pm_state, core_clk_en, chip_rst, fetch_start, fetch_addr,
      output bod_irq, bod_status, lposc_ready, dpd_refused, gp_rdata
   );

   modport host (
      output mode_req, sleep_instr, dpd_lock, start_enable_zero,
      output start_enable_one, vectored_int_ctrl_pin_en, vectored_int_ctrl_misc_en,
      output brownout_control_reg, sleep_power_config,
      output wake_pin_enable_reg, clk_sel_req, gp_wr, gp_idx, gp_wdata,
      input  pm_state, core_clk_en, chip_rst, fetch_start, fetch_addr,
      input  bod_irq, bod_status, lposc_ready, dpd_refused, gp_rdata
   );
endinterface

// ### pmw_host.sv
`timescale 1ns/1ps
`include "pmw_defines.svh"

module pmw_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Link to device
   pmw_if.host              lnk,
   // Software command port
   input  wire logic        cmd_valid,
   input  wire logic [3:0]  cmd_sel,
   input  wire logic [31:0] cmd_data,
   input  wire logic        sleep_cmd,
   // Serial peripheral setup
   input  wire logic        serial_slave_cfg,
   input  wire logic        ext_clk_present,
   // Clock setup outputs
   output logic             lposc_clock_enable,
   output logic             touch_clk_lposc,
   output logic             wkt_clk_lposc
);

   // ----------------------------------------------------------------------
   // Software-visible configuration
   // ----------------------------------------------------------------------
   pmw_pkg::pmw_mode_e      mode_reg, mode_next;
   pmw_pkg::pmw_bod_ctrl_s  bod_reg, bod_next;
   pmw_pkg::pmw_sleep_cfg_s spc_reg, spc_next;
   logic        lock_reg, lock_next;
   logic [7:0]  se0_reg, se0_next;
   logic [4:0]  se1_reg, se1_next;
   logic [7:0]  npin_reg, npin_next;
   logic [4:0]  nmisc_reg, nmisc_next;
   logic [7:0]  wake_reg, wake_next;
   logic        clk_reg, clk_next;
   logic        sleep_reg, sleep_next;
   logic        gpw_reg, gpw_next;
   logic [2:0]  gpi_reg, gpi_next;
   logic [31:0] gpd_reg, gpd_next;
   logic        lpc_reg, lpc_next;
   logic        tch_reg, tch_next;
   logic        wkt_reg, wkt_next;
   logic [4:0]  se1_w;

   always_comb begin
      mode_next  = mode_reg;
      lock_next  = lock_reg;
      se0_next   = se0_reg;
      se1_w      = se1_reg;
      npin_next  = npin_reg;
      nmisc_next = nmisc_reg;
      bod_next   = bod_reg;
      spc_next   = spc_reg;
      wake_next  = wake_reg;
      clk_next   = clk_reg;
      gpi_next   = gpi_reg;
      gpd_next   = gpd_reg;
      gpw_next   = 1'b0;
      if (cmd_valid) begin
         unique case (cmd_sel)
            `PMW_SEL_MODE: begin
               mode_next = pmw_pkg::pmw_mode_e'(cmd_data[1:0]);
               lock_next = cmd_data[2];
            end
            `PMW_SEL_SE0:  se0_next = cmd_data[7:0];
            `PMW_SEL_SE1:  se1_w = cmd_data[4:0];
            `PMW_SEL_VECTORED_INT_CTRL: begin
               npin_next  = cmd_data[7:0];
               nmisc_next = cmd_data[12:8];
            end
            `PMW_SEL_BOD:  bod_next = cmd_data[5:0];
            `PMW_SEL_SPC:  spc_next = cmd_data[1:0];
            `PMW_SEL_WAKE: wake_next = cmd_data[7:0];
            `PMW_SEL_CLK:  clk_next = cmd_data[0];
            `PMW_SEL_GPRD: gpi_next = cmd_data[2:0];
            default: begin
               if (cmd_sel >= `PMW_SEL_GP0 && cmd_sel < `PMW_SEL_GPRD) begin
                  gpw_next = 1'b1;
                  gpi_next = 3'(cmd_sel - `PMW_SEL_GP0);
                  gpd_next = cmd_data;
               end
            end
         endcase
      end
      // A serial wake is only honoured as a clocked slave.
      se1_w[`PMW_SE1_SER] = se1_w[`PMW_SE1_SER] && serial_slave_cfg &&
                            ext_clk_present;
      se1_next = se1_w;
      // Timer, watchdog and touch wake all need the low-power oscillator.
      lpc_next = se1_w[`PMW_SE1_WDT] || se1_w[`PMW_SE1_WKT] ||
                 se1_w[`PMW_SE1_TOUCH];
      spc_next.lposc_powered = spc_next.lposc_powered ||
                               lpc_next;
      wkt_next = se1_w[`PMW_SE1_WKT];
      tch_next = se1_w[`PMW_SE1_TOUCH];
      sleep_next = sleep_cmd && lnk.core_clk_en && !sleep_reg;
   end

   always_ff @(posedge clk) begin
      if (sys_rst || lnk.chip_rst) begin
         mode_reg  <= pmw_pkg::PMW_MODE_SLEEP;
         lock_reg  <= 1'b0;
         se0_reg   <= 8'h00;
         se1_reg   <= 5'h00;
         npin_reg  <= 8'h00;
         nmisc_reg <= 5'h00;
         bod_reg   <= '0;
         spc_reg   <= '0;
         wake_reg  <= 8'h00;
         clk_reg   <= 1'b0;
         sleep_reg <= 1'b0;
         gpw_reg   <= 1'b0;
         gpi_reg   <= 3'h0;
         gpd_reg   <= 32'h0000_0000;
         lpc_reg   <= 1'b0;
         tch_reg   <= 1'b0;
         wkt_reg   <= 1'b0;
      end else begin
         mode_reg  <= mode_next;
         lock_reg  <= lock_next;
         se0_reg   <= se0_next;
         se1_reg   <= se1_next;
         npin_reg  <= npin_next;
         nmisc_reg <= nmisc_next;
         bod_reg   <= bod_next;
         spc_reg   <= spc_next;
         wake_reg  <= wake_next;
         clk_reg   <= clk_next;
         sleep_reg <= sleep_next;
         gpw_reg   <= gpw_next;
         gpi_reg   <= gpi_next;
         gpd_reg   <= gpd_next;
         lpc_reg   <= lpc_next;
         tch_reg   <= tch_next;
         wkt_reg   <= wkt_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign lnk.mode_req             = mode_reg;
   assign lnk.dpd_lock             = lock_reg;
   assign lnk.sleep_instr          = sleep_reg;
   assign lnk.start_enable_zero    = se0_reg;
   assign lnk.start_enable_one     = se1_reg;
   assign lnk.vectored_int_ctrl_pin_en          = npin_reg;
   assign lnk.vectored_int_ctrl_misc_en         = nmisc_reg;
   assign lnk.brownout_control_reg = bod_reg;
   assign lnk.sleep_power_config   = spc_reg;
   assign lnk.wake_pin_enable_reg  = wake_reg;
   // Request a clock switch; the device waits for stability.
   assign lnk.clk_sel_req          = clk_reg;
   assign lnk.gp_wr                = gpw_reg;
   assign lnk.gp_idx               = gpi_reg;
   assign lnk.gp_wdata             = gpd_reg;
   assign lposc_clock_enable       = lpc_reg;
   assign touch_clk_lposc          = tch_reg;
   assign wkt_clk_lposc            = wkt_reg;

endmodule

// ### pmw_properties.sv
`timescale 1ns/1ps
module pmw_properties (
   // Watched link signals.
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic              sleep_instr,
   input wire logic              dpd_lock,
   input wire logic              core_clk_en,
   input wire logic              chip_rst,
   input wire logic              fetch_start,
   input wire logic              bod_irq,
   input wire logic              dpd_refused,
   input wire logic [31:0]       fetch_addr,
   input pmw_pkg::pmw_mode_e     mode_req,
   input pmw_pkg::pmw_state_e    pm_state,
   input pmw_pkg::pmw_bod_ctrl_s brownout_control_reg
);
   logic run;
   logic rst_st;
   assign run = pm_state == pmw_pkg::PMW_ST_RUN;
   assign rst_st = pm_state == pmw_pkg::PMW_ST_RESET;
   default clocking dc @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_CLK_RUN: assert property (core_clk_en == run)
      else $error("core clock mismatch");
   AST_RST_STATE: assert property (chip_rst == rst_st)
      else $error("chip reset mismatch");
   AST_RST_HOLD: assert property ($fell(chip_rst) |->
      $past(chip_rst, 8) && run) else $error("reset too short");
   AST_FETCH_ZERO: assert property (fetch_start |->
      fetch_addr == 32'h0000_0000 && run) else $error("bad fetch");
   AST_FETCH_ONCE: assert property ($rose(fetch_start) |->
      $past(rst_st) ##1 !fetch_start) else $error("fetch pulse");
   AST_LOCK: assert property (sleep_instr && dpd_lock &&
      run && mode_req == pmw_pkg::PMW_MODE_DPD |=> run && dpd_refused)
      else $error("lock ignored");
   AST_SLEEP: assert property (sleep_instr && run &&
      mode_req == pmw_pkg::PMW_MODE_SLEEP |=>
      pm_state == pmw_pkg::PMW_ST_SLEEP)
      else $error("sleep not entered");
   AST_BOD_IRQ: assert property (bod_irq |->
      $past(brownout_control_reg.int_en)) else $error("irq not enabled");
   CV_FETCH: cover property (fetch_start);
   CV_REFUSED: cover property (dpd_refused);
   CV_IRQ: cover property (bod_irq);
endmodule

// ### tb_power_mode_wake_reset_ctrl.sv
`timescale 1ns/1ps
module tb_power_mode_wake_reset_ctrl;
   logic        clk = 0, sys_rst = 1, cmd_valid = 0, sleep_cmd = 0;
   logic        misc = 0, rst_pin_n = 1, por = 0, wdt = 0, rdy = 0;
   logic        logic_pwr_en, flash_init, main_clk_sel;
   logic [3:0]  cmd_sel = 0, supply_below = 0;
   logic [7:0]  pin_irq = 0, wake_pin_n = 8'hff, se0;
   logic [31:0] cmd_data = 0, seed = 32'h2add8ed8, gv;
   int          bad_count = 0, total_checks = 0, k, p;
   pmw_if lnk ();
   pmw_device pmw_device_i (.clk, .sys_rst, .lnk, .pin_irq, .wake_pin_n,
      .wdt_irq(misc), .wkt_irq(misc), .serial_irq(misc), .touch_irq(misc),
      .rst_pin_n, .wdt_rst(wdt), .por, .supply_below, .lposc_stable(rdy),
      .logic_pwr_en, .wake_pin_pwr_en(), .fro_en(), .fro_out_en(),
      .flash_mode(), .flash_init, .periph_rst(), .main_clk_sel);
   pmw_host pmw_host_i (.clk, .sys_rst, .lnk, .cmd_valid, .cmd_sel,
      .cmd_data, .sleep_cmd, .serial_slave_cfg(1'b1),
      .ext_clk_present(1'b1), .lposc_clock_enable(), .touch_clk_lposc(),
      .wkt_clk_lposc());
   pmw_properties pmw_properties_i (.clk, .sys_rst,
      .sleep_instr(lnk.sleep_instr), .dpd_lock(lnk.dpd_lock),
      .core_clk_en(lnk.core_clk_en), .chip_rst(lnk.chip_rst),
      .fetch_start(lnk.fetch_start), .bod_irq(lnk.bod_irq),
      .dpd_refused(lnk.dpd_refused), .fetch_addr(lnk.fetch_addr),
      .mode_req(lnk.mode_req), .pm_state(lnk.pm_state),
      .brownout_control_reg(lnk.brownout_control_reg));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [2:0] exp_st(input logic [1:0] m, input logic lk);
      pmw_pkg::pmw_state_e t[4] = '{pmw_pkg::PMW_ST_SLEEP,
         pmw_pkg::PMW_ST_DSLEEP, pmw_pkg::PMW_ST_PDOWN, pmw_pkg::PMW_ST_DPD};
      return (m == 2'h3 && lk) ? pmw_pkg::PMW_ST_RUN : t[m];
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out(input bit hung);
      bad_count += hung;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_run();
      int i;
      for (i = 0; i < 40 && lnk.pm_state !== pmw_pkg::PMW_ST_RUN; i++) tick(1);
      if (i == 40) close_out(1);
   endtask
   task automatic cmd(input logic [3:0] s, input logic [31:0] d);
      cmd_valid <= 1;
      cmd_sel <= s;
      cmd_data <= d;
      tick(1);
      cmd_valid <= 0;
      tick(1);
   endtask
   task automatic nap(input logic [1:0] m, input logic lk);
      cmd(4'h0, {29'h0, lk, m});
      sleep_cmd <= 1;
      tick(1);
      sleep_cmd <= 0;
      tick(3);
      check(lnk.pm_state, exp_st(m, lk));
   endtask
   initial forever #2 clk = ~clk;
   initial begin
      tick(12);
      sys_rst <= 0;
      wait_run();
      check(lnk.fetch_addr, 0);
      check(main_clk_sel, 0);
      cmd(4'h7, 1);
      tick(2);
      check(main_clk_sel, 0);
      rdy <= 1;
      tick(3);
      check(main_clk_sel, 1);
      cmd(4'h3, 32'h1fff);
      nap(2'h0, 0);
      misc <= 1;
      tick(3);
      check(lnk.pm_state, pmw_pkg::PMW_ST_RUN);
      misc <= 0;
      for (k = 0; k < 6; k++) begin
         p = rnd() % 8;
         se0 = 8'(rnd());
         cmd(4'h1, se0);
         nap(2'(k % 2 + 1), 0);
         pin_irq <= 8'h1 << p;
         tick(3);
         check(lnk.pm_state,
               se0[p] ? 3'h1 : exp_st(2'(k % 2 + 1), 0));
         cmd(4'h1, 32'hff);
         wait_run();
         pin_irq <= 0;
      end
      nap(2'h3, 1);
      for (k = 0; k < 4; k++) begin
         supply_below <= 4'(rnd());
         cmd(4'h4, 32'h20 | k << 2);
         tick(2);
         check(lnk.bod_status, k < 3 && supply_below[k]);
         check(lnk.bod_irq, k < 3 && supply_below[k]);
      end
      supply_below <= 4'h4;
      cmd(4'h4, 32'h12);
      tick(2);
      check(lnk.chip_rst, 1);
      supply_below <= 0;
      wait_run();
      p = rnd() % 5;
      gv = rnd();
      cmd(4'(8 + p), gv);
      cmd(4'h6, 32'h1 << p);
      nap(2'h3, 0);
      check(logic_pwr_en, 0);
      misc <= 1;
      pin_irq <= 8'hff;
      wake_pin_n <= 8'h1 << p;
      tick(4);
      check(lnk.pm_state, pmw_pkg::PMW_ST_DPD);
      misc <= 0;
      pin_irq <= 0;
      wake_pin_n <= ~(8'h1 << p);
      tick(2);
      wake_pin_n <= 8'hff;
      wait_run();
      cmd(4'hd, p);
      tick(2);
      check(lnk.gp_rdata, gv);
      for (k = 0; k < 3; k++) begin
         if (k == 1) rst_pin_n <= 0;
         else if (k == 2) wdt <= 1;
         else por <= 1;
         tick(2);
         check(flash_init, 1);
         check(lnk.chip_rst, 1);
         por <= 0;
         rst_pin_n <= 1;
         wdt <= 0;
         wait_run();
      end
      close_out(0);
   end
endmodule
